// File: src/dpm_consts.vh
// Purpose: Constants for the dual-port memory port host controller
// Assumes: 200 MHz system clock, 16-bit address, 18-bit data
// Notes:   Times in ns, cycle counts derived from them
`ifndef DPM_CONSTS_VH
`define DPM_CONSTS_VH

// ****************************************
// Clock and timing figures
// ****************************************
`define DPM_CLK_MHZ        200
`define DPM_TWP_NS         12
`define DPM_TWZ_NS         10
`define DPM_TDW_NS         10
`define DPM_TWH_NS         12
`define DPM_TAA_NS         15
`define DPM_TSOP_NS        10
`define DPM_TWB_NS         0
`define DPM_CEIL_CYC(ns)   (((ns) * `DPM_CLK_MHZ + 999) / 1000)
`define DPM_SYNC_CYC       2

// ****************************************
// Address map and field layout
// ****************************************
`define DPM_ADDR_W         16
`define DPM_DATA_W         18
`define DPM_MBOX_RIGHT     16'hFFFF
`define DPM_MBOX_LEFT      16'hFFFE
`define DPM_SEM_ADDR_W     3
`define DPM_SEM_BIT        0
`define DPM_SEM_FREE       1'h1
`define DPM_SEM_CLAIM      1'h0

`endif

// File: src/dpm_host.v
// Purpose: Host controller driving one port of an asynchronous dual-port memory
// Assumes: Single clock, pins from the memory pass a two-flop synchroniser
// Notes:   One access at a time; output enable stays high during writes
`timescale 1ns/100ps
`include "dpm_consts.vh"

// Function
// - Address changes only while write strobe, select and lanes are high.
// - Array uses select low, flag high; flags use opposite, held whole cycle.
// - Write with output drive on is stretched past driver turn-off plus setup.
// - Slave-role collision input goes low no later than write start.
// - After collision deasserts, write strobe stays low at least 12 ns.
// - Hosts put mailbox flags into a known state after power-up.
module dpm_host #(
    parameter             ADDR_W     = `DPM_ADDR_W,
    parameter             DATA_W     = `DPM_DATA_W,
    parameter             SLAVE_ROLE = 0,
    parameter [15:0]      MBOX_OWN   = `DPM_MBOX_RIGHT
) (
    input  wire              CLK,
    input  wire              SYS_RST,
    input  wire              REQ,
    input  wire              REQ_WRITE,
    input  wire              REQ_FLAG,
    input  wire [1:0]        REQ_LANES,
    input  wire [ADDR_W-1:0] REQ_ADDR,
    input  wire [DATA_W-1:0] REQ_WDATA,
    input  wire              INHIBIT,
    output reg               READY,
    output reg               ACK,
    output reg  [DATA_W-1:0] RDATA,
    output reg               COLLIDED,
    output reg               MBOX_FLAG_N,
    output reg               SELECT_N,
    output reg               WRITE_N,
    output reg               OUT_EN_N,
    output reg               FLAG_SELECT_N,
    output reg               UPPER_LANE_SELECT_N,
    output reg               LOWER_LANE_SELECT_N,
    output reg  [ADDR_W-1:0] ADDR,
    output reg  [DATA_W-1:0] DQ_O,
    output reg               DQ_OE,
    input  wire [DATA_W-1:0] DQ_I,
    input  wire              BUSY_N_I,
    output reg               BUSY_N_O,
    output reg               BUSY_N_OE,
    input  wire              MBOX_N_I
);

    // ****************************************
    // Timing counts
    // ****************************************
    localparam [31:0] TWP_FULL  = `DPM_CEIL_CYC(`DPM_TWP_NS);
    localparam [31:0] TWZD_FULL = `DPM_CEIL_CYC(`DPM_TWZ_NS + `DPM_TDW_NS);
    // Busy and data are seen two cycles late, so write, hold and read waits cover the synchroniser
    localparam [31:0] TWR_FULL  = ((TWP_FULL > TWZD_FULL) ? TWP_FULL : TWZD_FULL)
                                  + `DPM_SYNC_CYC;
    localparam [31:0] TWH_FULL  = `DPM_CEIL_CYC(`DPM_TWH_NS) + `DPM_SYNC_CYC;
    localparam [31:0] TRD_FULL  = `DPM_CEIL_CYC(`DPM_TAA_NS) + `DPM_SYNC_CYC;
    localparam [31:0] TREC_FULL = `DPM_CEIL_CYC(`DPM_TSOP_NS);
    // All counts fit the five-bit counter, upper bits dropped on purpose
    localparam [4:0]  TWR_CYC   = TWR_FULL[4:0];
    localparam [4:0]  TWH_CYC   = TWH_FULL[4:0];
    localparam [4:0]  TRD_CYC   = TRD_FULL[4:0];
    localparam [4:0]  TREC_CYC  = TREC_FULL[4:0];

    localparam [5:0] ST_INIT  = 6'h01;
    localparam [5:0] ST_IDLE  = 6'h02;
    localparam [5:0] ST_SETUP = 6'h04;
    localparam [5:0] ST_WRITE = 6'h08;
    localparam [5:0] ST_READ  = 6'h10;
    localparam [5:0] ST_REC   = 6'h20;

    reg [5:0]        state_reg;
    reg [4:0]        cnt_reg;
    reg              init_reg;
    reg              wr_reg;
    reg              flag_reg;
    reg [DATA_W-1:0] dq_meta_reg;
    reg [DATA_W-1:0] dq_sync_reg;
    reg              busy_meta_reg;
    reg              busy_sync_reg;
    reg              mbox_meta_reg;
    reg              mbox_sync_reg;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dq_meta_reg   <= {DATA_W{1'b0}};
            dq_sync_reg   <= {DATA_W{1'b0}};
            busy_meta_reg <= 1'b1;
            busy_sync_reg <= 1'b1;
            mbox_meta_reg <= 1'b1;
            mbox_sync_reg <= 1'b1;
        end else begin
            dq_meta_reg   <= DQ_I;
            dq_sync_reg   <= dq_meta_reg;
            busy_meta_reg <= BUSY_N_I;
            busy_sync_reg <= busy_meta_reg;
            mbox_meta_reg <= MBOX_N_I;
            mbox_sync_reg <= mbox_meta_reg;
        end
    end

    // ****************************************
    // Access sequencer
    // ****************************************
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg           <= ST_INIT;
            cnt_reg             <= 5'h00;
            init_reg            <= 1'b1;
            wr_reg              <= 1'b0;
            flag_reg            <= 1'b0;
            READY               <= 1'b0;
            ACK                 <= 1'b0;
            RDATA               <= {DATA_W{1'b0}};
            COLLIDED            <= 1'b0;
            MBOX_FLAG_N         <= 1'b1;
            SELECT_N            <= 1'b1;
            WRITE_N             <= 1'b1;
            OUT_EN_N            <= 1'b1;
            FLAG_SELECT_N       <= 1'b1;
            UPPER_LANE_SELECT_N <= 1'b1;
            LOWER_LANE_SELECT_N <= 1'b1;
            ADDR                <= {ADDR_W{1'b0}};
            DQ_O                <= {DATA_W{1'b0}};
            DQ_OE               <= 1'b0;
            BUSY_N_O            <= 1'b1;
            BUSY_N_OE           <= 1'b0;
        end else begin
            ACK         <= 1'b0;
            MBOX_FLAG_N <= mbox_sync_reg;
            BUSY_N_OE   <= (SLAVE_ROLE != 0);
            // Inhibit updates while idle so it leads any write strobe
            if (state_reg == ST_IDLE) begin
                BUSY_N_O <= ~INHIBIT;
            end
            case (state_reg)
                ST_INIT: begin
                    // Own mailbox read clears the flag left over from power-up
                    ADDR     <= MBOX_OWN[ADDR_W-1:0];
                    wr_reg   <= 1'b0;
                    flag_reg <= 1'b0;
                    state_reg <= ST_SETUP;
                end
                ST_IDLE: begin
                    READY <= 1'b1;
                    if (REQ) begin
                        READY    <= 1'b0;
                        COLLIDED <= 1'b0;
                        wr_reg   <= REQ_WRITE;
                        flag_reg <= REQ_FLAG;
                        // All strobes are high here, so the address may move
                        ADDR     <= REQ_ADDR;
                        DQ_O     <= REQ_FLAG ? {{(DATA_W-1){1'b1}}, REQ_WDATA[`DPM_SEM_BIT]}
                                             : REQ_WDATA;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    SELECT_N      <= flag_reg;
                    FLAG_SELECT_N <= ~flag_reg;
                    UPPER_LANE_SELECT_N <= init_reg ? 1'b0 : ~REQ_LANES[1];
                    LOWER_LANE_SELECT_N <= init_reg ? 1'b0 : ~REQ_LANES[0];
                    if (flag_reg) begin
                        UPPER_LANE_SELECT_N <= 1'b1;
                        LOWER_LANE_SELECT_N <= 1'b1;
                    end
                    if (wr_reg) begin
                        WRITE_N  <= 1'b0;
                        OUT_EN_N <= 1'b1;
                        DQ_OE    <= 1'b1;
                        cnt_reg  <= TWR_CYC;
                        state_reg <= ST_WRITE;
                    end else begin
                        OUT_EN_N <= 1'b0;
                        cnt_reg  <= TRD_CYC;
                        state_reg <= ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (!busy_sync_reg && (SLAVE_ROLE == 0)) begin
                        // Strobe held until collision clears, then hold time runs
                        COLLIDED <= 1'b1;
                        cnt_reg  <= TWH_CYC;
                    end else if (cnt_reg > 5'h01) begin
                        cnt_reg <= cnt_reg - 5'h01;
                    end else begin
                        WRITE_N       <= 1'b1;
                        SELECT_N      <= 1'b1;
                        FLAG_SELECT_N <= 1'b1;
                        UPPER_LANE_SELECT_N <= 1'b1;
                        LOWER_LANE_SELECT_N <= 1'b1;
                        cnt_reg  <= TREC_CYC;
                        state_reg <= ST_REC;
                    end
                end
                ST_READ: begin
                    if (cnt_reg > 5'h01) begin
                        cnt_reg <= cnt_reg - 5'h01;
                    end else begin
                        RDATA <= flag_reg ? {DATA_W{dq_sync_reg[`DPM_SEM_BIT]}} : dq_sync_reg;
                        OUT_EN_N      <= 1'b1;
                        SELECT_N      <= 1'b1;
                        FLAG_SELECT_N <= 1'b1;
                        UPPER_LANE_SELECT_N <= 1'b1;
                        LOWER_LANE_SELECT_N <= 1'b1;
                        cnt_reg  <= TREC_CYC;
                        state_reg <= ST_REC;
                    end
                end
                ST_REC: begin
                    // Data released only after strobes rose, giving hold margin
                    DQ_OE <= 1'b0;
                    if (cnt_reg > 5'h01) begin
                        cnt_reg <= cnt_reg - 5'h01;
                    end else begin
                        ACK      <= ~init_reg;
                        init_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_INIT;
                end
            endcase
        end
    end

endmodule

// File: tb/dpm_host_properties.sv
// Purpose: Port checks for the dual-port memory host controller
// Assumes: Master role, one clock
// Notes:   Bound into every dpm_host
`timescale 1ns/100ps
// ****************************************
// Checker
// ****************************************
module dpm_host_properties (
    input wire        CLK,
    input wire        SYS_RST,
    input wire        REQ,
    input wire        REQ_WRITE,
    input wire        READY,
    input wire        SELECT_N,
    input wire        WRITE_N,
    input wire        OUT_EN_N,
    input wire        FLAG_SELECT_N,
    input wire        UPPER_LANE_SELECT_N,
    input wire        LOWER_LANE_SELECT_N,
    input wire        DQ_OE,
    input wire [15:0] ADDR,
    input wire        BUSY_N_I
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_take_rd; REQ && READY && !REQ_WRITE; endsequence
    sequence s_rd_open; !OUT_EN_N && (SELECT_N != FLAG_SELECT_N); endsequence
    sequence s_wr_open; $fell(WRITE_N); endsequence
    a_addr_steady: assert property ($changed(ADDR) |-> WRITE_N && SELECT_N && FLAG_SELECT_N)
        else $error("address moved during an access");
    a_sel_excl: assert property (SELECT_N || FLAG_SELECT_N)
        else $error("array and flag selected together");
    a_sel_hold: assert property ($fell(SELECT_N) |-> !SELECT_N [*4])
        else $error("array select dropped early");
    a_flag_hold: assert property ($fell(FLAG_SELECT_N) |-> !FLAG_SELECT_N [*4])
        else $error("flag select dropped early");
    a_rd_opens: assert property (s_take_rd |-> ##[1:3] s_rd_open)
        else $error("read did not open one select");
    a_wr_pulse: assert property (s_wr_open |-> !WRITE_N [*4])
        else $error("write pulse too short");
    a_wr_quiet: assert property (!WRITE_N |-> OUT_EN_N)
        else $error("output drive on during write");
    a_wr_drives: assert property (!WRITE_N |-> DQ_OE)
        else $error("write strobe low without data driven");
    a_flag_lanes: assert property (!FLAG_SELECT_N |-> UPPER_LANE_SELECT_N && LOWER_LANE_SELECT_N)
        else $error("byte lane open during flag access");
    // Sync delay in the design makes three cycles a safe floor
    a_busy_hold: assert property ($rose(BUSY_N_I) && !WRITE_N |-> !WRITE_N [*3])
        else $error("write ended too soon after busy");
endmodule
bind dpm_host dpm_host_properties dpm_host_properties_inst (.*);

// File: tb/dpm_dev_model.sv
// Purpose: One port of the dual-port memory, seen from its host
// Assumes: Peer port actions come from the bench
// Notes:   Sixteen array words only, keyed by low address bits
`timescale 1ns/100ps
// ****************************************
// Device port
// ****************************************
module dpm_dev_model #(
    // Own mailbox word; a left-port host would use the other one
    parameter [15:0] MBOX_ADDR = 16'hFFFF
) (
    input  wire        CLK,
    input  wire        SELECT_N,
    input  wire        WRITE_N,
    input  wire        OUT_EN_N,
    input  wire        FLAG_SELECT_N,
    input  wire [15:0] ADDR,
    input  wire [17:0] DQ_O,
    output wire [17:0] DQ_I,
    output wire        BUSY_N_I,
    output reg         MBOX_N_I,
    input  wire        clash,
    input  wire [7:0]  peer,
    input  wire        poke
);
    reg [17:0] mem [0:15];
    reg [17:0] wd, junk = 18'h2AAAA;
    reg [15:0] wad;
    reg [7:0]  own = 8'h00, pnd = 8'h00;
    reg        wa = 1'h0, wf, wok;
    wire       rd = !OUT_EN_N && WRITE_N && !(SELECT_N && FLAG_SELECT_N);
    // Write window is the overlap of strobe and a select
    wire       wr_on = !WRITE_N && !(SELECT_N && FLAG_SELECT_N);
    initial MBOX_N_I = 1'h0;
    assign BUSY_N_I = !(clash && !SELECT_N);
    // Junk, not the last value, so a floating bus never matches
    assign DQ_I = !rd ? junk : !SELECT_N ? mem[ADDR[3:0]] : {18{!own[ADDR[2:0]]}};
    always @(posedge CLK) begin
        junk <= ~junk;
        pnd  <= pnd & peer;
        own  <= own | (pnd & ~peer);
        wa   <= wr_on;
        wd   <= DQ_O;
        wad  <= ADDR;
        wf   <= !FLAG_SELECT_N;
        wok  <= BUSY_N_I;
        if (wa && !wr_on && wok && !wf) mem[wad[3:0]] <= wd;
        if (wa && !wr_on && wf) begin
            own[wad[2:0]] <= !wd[0] && !peer[wad[2:0]];
            pnd[wad[2:0]] <= !wd[0] && peer[wad[2:0]];
        end
        if (poke) MBOX_N_I <= 1'h0;
        if (rd && !SELECT_N && ADDR == MBOX_ADDR) MBOX_N_I <= 1'h1;
    end
endmodule

// File: tb/dpm_host_bench.sv
// Purpose: Self-checking bench for the dual-port memory host controller
// Assumes: Master role device model on the far side
// Notes:   Random array traffic plus collision, flag and mailbox cases
`timescale 1ns/100ps
// ****************************************
// Bench
// ****************************************
module dpm_host_bench;
    logic CLK = 1'h0, SYS_RST = 1'h1, REQ = 1'h0, REQ_WRITE = 1'h0, REQ_FLAG = 1'h0;
    logic INHIBIT = 1'h0, clash = 1'h0, poke = 1'h0, READY, ACK, COLLIDED, MBOX_FLAG_N;
    logic SELECT_N, WRITE_N, OUT_EN_N, FLAG_SELECT_N, UPPER_LANE_SELECT_N, LOWER_LANE_SELECT_N;
    logic DQ_OE, BUSY_N_I, BUSY_N_O, BUSY_N_OE, MBOX_N_I;
    logic [1:0]  REQ_LANES = 2'h3;
    logic [7:0]  peer = 8'h00;
    logic [15:0] REQ_ADDR = 16'h0000, ADDR, a;
    logic [17:0] REQ_WDATA = 18'h00000, RDATA, DQ_O, DQ_I, rd, d;
    int          fails = 0, n_compared = 0, cyc = 0, i;
    dpm_host dpm_host_inst (.*);
    dpm_dev_model dpm_dev_model_inst (.*);
    always #2.5 CLK = ~CLK;
    function automatic logic [17:0] sem_exp(input logic held);
        return {18{held}};
    endfunction
    task automatic chk(input logic [17:0] exp, got, input string nm);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input logic w, f, input logic [15:0] ad, input logic [17:0] wd);
        while (READY !== 1'h1) @(negedge CLK);
        @(posedge CLK);
        REQ <= 1'h1;
        REQ_WRITE <= w;
        REQ_FLAG <= f;
        REQ_ADDR <= ad;
        REQ_WDATA <= wd;
        @(posedge CLK);
        REQ <= 1'h0;
        @(negedge CLK);
        while (ACK !== 1'h1) @(negedge CLK);
        rd = RDATA;
    endtask
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            wrap_up;
        end
    end
    initial begin
        void'($urandom(32'h7E7DDA62));
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'h0;
        repeat (20) @(negedge CLK);
        chk(18'h1, MBOX_FLAG_N, "mailbox after init");
        for (i = 0; i < 12; i++) begin
            a = 16'($urandom_range(16'hFFF0));
            d = i == 0 ? 18'h3FFFF : 18'($urandom);
            @(posedge CLK) INHIBIT <= 1'($urandom);
            acc(1'h1, 1'h0, a, d);
            acc(1'h0, 1'h0, a, 18'h0);
            chk(d, rd, "array word");
            chk(INHIBIT ? 18'h0 : 18'h1, BUSY_N_O, "busy drive level");
            chk(18'h0, BUSY_N_OE, "busy drive enable");
        end
        clash <= 1'h1;
        fork
            acc(1'h1, 1'h0, a, ~d);
            #60 clash <= 1'h0;
        join
        chk(18'h1, COLLIDED, "collision flag");
        acc(1'h0, 1'h0, a, 18'h0);
        chk(~d, rd, "write after collision");
        for (i = 0; i < 8; i++) begin
            peer <= i[0] ? 8'h01 << i : 8'h00;
            acc(1'h1, 1'h1, 16'(i), 18'h0);
            acc(1'h0, 1'h1, 16'(i), 18'h0);
            chk(sem_exp(i[0]), rd, "flag claim");
            peer <= 8'h00;
            acc(1'h0, 1'h1, 16'(i), 18'h0);
            chk(sem_exp(1'h0), rd, "flag handed over");
            acc(1'h1, 1'h1, 16'(i), 18'h1);
            acc(1'h0, 1'h1, 16'(i), 18'h0);
            chk(sem_exp(1'h1), rd, "flag release");
        end
        @(posedge CLK) poke <= 1'h1;
        @(posedge CLK) poke <= 1'h0;
        repeat (4) @(negedge CLK);
        chk(18'h0, MBOX_FLAG_N, "mailbox raised");
        acc(1'h0, 1'h0, 16'hFFFF, 18'h0);
        repeat (4) @(negedge CLK);
        chk(18'h1, MBOX_FLAG_N, "mailbox cleared");
        wrap_up;
    end
endmodule
